// ---- logic/kil_defines.svh ----
// constants for the keypad interrupt latch
// How it works
// - four pin inputs, each enabled separately, one shared mask
// - enabling a pin as interrupt input turns on its pull-up
// - latch request when an enabled input falls while all were high
// - edge-only: no new request while another enabled input is low
// - edge-and-level: request held while any enabled input is low
// - level mode clears after both acknowledge and all inputs high, any order
// - vector fetch acknowledges and clears the latched request
// - writing 1 to the acknowledge bit acts like a vector fetch
// - a falling edge after an acknowledge latches a fresh request
// - unmasked request goes to the cpu, vector pair FFDE and FFDF
// - edge-only: acknowledge clears the request at once
// - reset clears request and sensitivity select even with inputs low
// - pending flag shows the request whatever the mask
// - enable forces the pin to input; level readable only with direction 0
// - acknowledge bit reads 0; mask set stops the cpu request
// - block stays active in wait and stop; unmasked request wakes cpu
// - in break, acknowledge writes ignored unless break clear enable set
`ifndef KIL_DEFINES_SVH
`define KIL_DEFINES_SVH
`define KIL_NPINS 4
`define KIL_CTL_MODE_BIT 0
`define KIL_CTL_MASK_BIT 1
`define KIL_CTL_ACK_BIT 2
`define KIL_CTL_FLAG_BIT 3
`define KIL_VEC_ADDR_HI 16'hFFDE
`define KIL_VEC_ADDR_LO 16'hFFDF
`define KIL_RST_EN 4'h0
`define KIL_RST_BYTE 8'h00
`define KIL_PIN_IDLE 4'hF
`endif

// ---- logic/kil_pkg.sv ----
// types for the keypad interrupt latch
package kil_pkg;
   typedef enum logic {
      KIL_EDGE_ONLY = 1'b0,
      KIL_EDGE_LEVEL = 1'b1
   } kil_mode_t;
endpackage

// ---- logic/kil_sync_if.sv ----
// carrier for synchronised pin levels
`timescale 1ns/1ps
interface kil_sync_if;
   logic [3:0] lvl;
   modport src (output lvl);
   modport dst (input lvl);
endinterface

// ---- logic/kil_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "kil_defines.svh"
module kil_pin_sync (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_pin,
   kil_sync_if.src sync
);
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic [3:0] s3_r;
   logic [3:0] lvl_r;

   // s1 feeds only s2; pins idle high through the pull-ups
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_r <= `KIL_PIN_IDLE;
         s2_r <= `KIL_PIN_IDLE;
         s3_r <= `KIL_PIN_IDLE;
      end else begin
         s1_r <= i_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit changes only once stages two and three agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lvl_r <= `KIL_PIN_IDLE;
      end else begin
         for (int i = 0; i < `KIL_NPINS; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               lvl_r[i] <= s3_r[i];
            end
         end
      end
   end

   assign sync.lvl = lvl_r;
endmodule

// ---- logic/kil_top.sv ----
// keypad interrupt latch, top level
`timescale 1ns/1ps
`include "kil_defines.svh"
module kil_top (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_port_pin,
   input wire logic [3:0] i_port_data,
   input wire logic [3:0] i_port_direction_bits,
   input wire logic i_ctl_wr,
   input wire logic [7:0] i_ctl_wdata,
   input wire logic i_en_wr,
   input wire logic [7:0] i_en_wdata,
   input wire logic i_vector_fetch,
   input wire logic i_break_state,
   input wire logic i_break_clear_enable,
   output logic [3:0] o_port_pin,
   output logic [3:0] o_port_pin_oe,
   output logic [3:0] o_pullup_en,
   output logic [3:0] o_port_rd,
   output logic [7:0] o_kbd_status_control,
   output logic [7:0] o_kbd_pin_enable_reg,
   output logic o_irq_req,
   output logic o_wake,
   output logic o_pending_flag,
   output logic [15:0] o_vector_addr
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [3:0] pin_irq_enable_bits_r;
   logic shared_mask_bit_r;
   kil_pkg::kil_mode_t sensitivity_select_r;
   logic req_r;
   logic req_nxt;
   logic ack_seen_r;
   logic ack_seen_nxt;
   logic low_prev_r;
   logic low_now;
   logic fall;
   logic ack;
   logic sw_ack;
   kil_sync_if sync_bus ();

   // true when any enabled input is low
   function automatic logic kil_any_low(input logic [3:0] en, input logic [3:0] lvl);
      kil_any_low = |(en & ~lvl);
   endfunction

   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   kil_pin_sync u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_port_pin),
      .sync(sync_bus.src)
   );

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_irq_enable_bits_r <= `KIL_RST_EN;
      end else if (i_en_wr) begin
         pin_irq_enable_bits_r <= i_en_wdata[3:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shared_mask_bit_r <= 1'b0;
         sensitivity_select_r <= kil_pkg::KIL_EDGE_ONLY;
      end else if (i_ctl_wr) begin
         shared_mask_bit_r <= i_ctl_wdata[`KIL_CTL_MASK_BIT];
         sensitivity_select_r <= kil_pkg::kil_mode_t'(i_ctl_wdata[`KIL_CTL_MODE_BIT]);
      end
   end

   // ------------------------------------------------------------
   // acknowledge
   // ------------------------------------------------------------
   // break protects the latch from acknowledge writes unless clearing is allowed
   assign sw_ack = i_ctl_wr & i_ctl_wdata[`KIL_CTL_ACK_BIT]
                   & (~i_break_state | i_break_clear_enable);
   assign ack = i_vector_fetch | sw_ack;

   // ------------------------------------------------------------
   // edge and level detection
   // ------------------------------------------------------------
   // newly enabled pins already low count as an edge: a false request
   // that the setup sequence is meant to acknowledge away
   assign low_now = kil_any_low(pin_irq_enable_bits_r, sync_bus.lvl);
   assign fall = low_now & ~low_prev_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         low_prev_r <= 1'b0;
      end else begin
         low_prev_r <= low_now;
      end
   end

   // ------------------------------------------------------------
   // request latch
   // ------------------------------------------------------------
   always_comb begin
      req_nxt = req_r;
      ack_seen_nxt = ack_seen_r;
      unique case (sensitivity_select_r)
         kil_pkg::KIL_EDGE_ONLY: begin
            req_nxt = req_r & ~ack;
            ack_seen_nxt = 1'b0;
         end
         kil_pkg::KIL_EDGE_LEVEL: begin
            // ack and release may come in either order
            if (req_r & (ack | ack_seen_r) & ~low_now) begin
               req_nxt = 1'b0;
               ack_seen_nxt = 1'b0;
            end else if (req_r & ack) begin
               ack_seen_nxt = 1'b1;
            end
         end
      endcase
      // a new edge wins over any clear
      if (fall) begin
         req_nxt = 1'b1;
         ack_seen_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         req_r <= 1'b0;
         ack_seen_r <= 1'b0;
      end else begin
         req_r <= req_nxt;
         ack_seen_r <= ack_seen_nxt;
      end
   end

   // ------------------------------------------------------------
   // cpu side outputs
   // ------------------------------------------------------------
   // nothing here is clock gated, so wait and stop leave it running
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_req <= 1'b0;
         o_wake <= 1'b0;
         o_pending_flag <= 1'b0;
         o_vector_addr <= `KIL_VEC_ADDR_HI;
      end else begin
         o_irq_req <= req_nxt & ~shared_mask_bit_r;
         o_wake <= req_nxt & ~shared_mask_bit_r;
         o_pending_flag <= req_nxt;
         o_vector_addr <= `KIL_VEC_ADDR_HI;
      end
   end

   // ------------------------------------------------------------
   // readback
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_kbd_status_control <= `KIL_RST_BYTE;
         o_kbd_pin_enable_reg <= `KIL_RST_BYTE;
      end else begin
         o_kbd_status_control <= `KIL_RST_BYTE;
         o_kbd_status_control[`KIL_CTL_FLAG_BIT] <= req_nxt;
         o_kbd_status_control[`KIL_CTL_MASK_BIT] <= shared_mask_bit_r;
         o_kbd_status_control[`KIL_CTL_MODE_BIT] <= sensitivity_select_r;
         // ack bit position left at 0
         o_kbd_pin_enable_reg <= {4'h0, pin_irq_enable_bits_r};
      end
   end

   // ------------------------------------------------------------
   // pin drive, pull-ups, port read
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_port_pin <= 4'h0;
         o_port_pin_oe <= 4'h0;
         o_pullup_en <= 4'h0;
         o_port_rd <= 4'h0;
      end else begin
         o_port_pin <= i_port_data;
         // enable overrides the direction bit
         o_port_pin_oe <= i_port_direction_bits & ~pin_irq_enable_bits_r;
         o_pullup_en <= pin_irq_enable_bits_r;
         // pin level only where direction is 0
         o_port_rd <= (sync_bus.lvl & ~i_port_direction_bits)
                      | (i_port_data & i_port_direction_bits);
      end
   end
endmodule

// ---- testbench/kil_keypad_model.sv ----
// keypad switch model on the four port pins
`timescale 1ns/1ps
module kil_keypad_model (
   input wire logic i_clk,
   input wire logic [3:0] i_press,
   input wire logic [3:0] i_pullup,
   output logic [3:0] o_lvl
);
   logic [3:0] flt_r = 4'h5;
   // an open pin without pull-up wanders, never a steady level
   always @(posedge i_clk) begin
      flt_r <= ~flt_r;
   end
   assign o_lvl = ~i_press & (i_pullup | flt_r);
endmodule

// ---- testbench/kil_top_props.sv ----
// port checker for the keypad interrupt latch
`timescale 1ns/1ps
module kil_top_props (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_port_pin,
   input wire logic i_vector_fetch,
   input wire logic [7:0] o_kbd_status_control,
   input wire logic [7:0] o_kbd_pin_enable_reg,
   input wire logic [3:0] o_pullup_en,
   input wire logic [3:0] o_port_pin_oe,
   input wire logic o_irq_req,
   input wire logic o_wake,
   input wire logic o_pending_flag,
   input wire logic [15:0] o_vector_addr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [3:0] low;
   assign low = ~i_port_pin & o_kbd_pin_enable_reg[3:0];
   ack_reads_zero_a: assert property (o_kbd_status_control[7:4] == 4'h0
      && !o_kbd_status_control[2]) else $error("status byte bits 7:4 or 2 set");
   irq_needs_pend_a: assert property (o_irq_req |-> o_pending_flag)
      else $error("request without pending flag");
   wake_follows_a: assert property (o_wake == o_irq_req)
      else $error("wake differs from request");
   pullup_on_en_a: assert property (o_pullup_en == o_kbd_pin_enable_reg[3:0])
      else $error("pull-up differs from enable");
   en_forces_in_a: assert property ((o_port_pin_oe & o_pullup_en) == 4'h0)
      else $error("enabled pin driven");
   vector_pair_a: assert property (o_vector_addr == 16'hFFDE)
      else $error("wrong vector address");
   mask_blocks_a: assert property (o_kbd_status_control[1] [*3] |-> !o_irq_req)
      else $error("masked request reached cpu");
   edge_ack_a: assert property ((i_port_pin == 4'hF) [*6] ##0
      (i_vector_fetch && !o_kbd_status_control[0]) |=> !o_pending_flag)
      else $error("fetch did not clear request");
   level_hold_a: assert property ((low != 4'h0) [*6] ##0
      (o_kbd_status_control[0] && o_pending_flag) |=> o_pending_flag)
      else $error("level request dropped");
   reset_clears_a: assert property ($fell(i_rst) |->
      (o_kbd_status_control == 8'h00 && !o_pending_flag)) else $error("reset left state");
   cover property (o_irq_req);
   cover property (o_pending_flag && o_kbd_status_control[0]);
   cover property ($fell(o_pending_flag));
endmodule
bind kil_top kil_top_props p (.i_clk, .i_rst, .i_port_pin, .i_vector_fetch,
   .o_kbd_status_control, .o_kbd_pin_enable_reg, .o_pullup_en, .o_port_pin_oe,
   .o_irq_req, .o_wake, .o_pending_flag, .o_vector_addr);

// ---- testbench/kil_top_tb.sv ----
// self-checking bench for the keypad interrupt latch
`timescale 1ns/1ps
module kil_top_tb;
   logic clk = 1'b0, rst = 1'b1, cw = 1'b0, ew = 1'b0, vf = 1'b0, bs = 1'b0, bce = 1'b0;
   logic [3:0] dat = 4'h0, dir = 4'h0, key = 4'h0, lvl, pin, opin, oe, pu, rd;
   logic [7:0] cd = 8'h00, ed = 8'h00, st, en;
   logic irq, wk, pf;
   logic [15:0] va;
   int n_mismatch = 0, n_checks = 0;
   always #5 clk = ~clk;
   assign pin = (oe & opin) | (~oe & lvl);
   kil_keypad_model km (.i_clk(clk), .i_press(key), .i_pullup(pu), .o_lvl(lvl));
   kil_top uut (.i_clk(clk), .i_rst(rst), .i_port_pin(pin), .i_port_data(dat),
      .i_port_direction_bits(dir), .i_ctl_wr(cw), .i_ctl_wdata(cd), .i_en_wr(ew),
      .i_en_wdata(ed), .i_vector_fetch(vf), .i_break_state(bs), .i_break_clear_enable(bce),
      .o_port_pin(opin), .o_port_pin_oe(oe), .o_pullup_en(pu), .o_port_rd(rd),
      .o_kbd_status_control(st), .o_kbd_pin_enable_reg(en), .o_irq_req(irq),
      .o_wake(wk), .o_pending_flag(pf), .o_vector_addr(va));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // strobes {ctl, enable, fetch}, one cycle each
   task automatic pulse(logic [2:0] s, logic [7:0] b);
      @(posedge clk);
      {cw, ew, vf} <= s;
      cd <= b;
      ed <= b;
      @(posedge clk);
      {cw, ew, vf} <= 3'b000;
      #1;
   endtask
   // step off the edge so no caller samples outputs as they launch
   task automatic drv(logic [3:0] k);
      @(posedge clk);
      key <= k;
      #1;
   endtask
   // pin path is a few syncing stages, so poll with a bound
   task automatic wpf(logic e);
      int i;
      for (i = 0; i < 12 && pf !== e; i++) tick(1);
      chk("pending", 16'(pf), 16'(e));
      if (pf !== e) give_verdict();
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      chk("status", 16'(st), 16'h0000);
      chk("enables", 16'(en), 16'h0000);
      chk("vector", va, 16'hFFDE);
      pulse(3'b100, 8'h02);
      pulse(3'b010, 8'hFF);
      tick(8);
      pulse(3'b100, 8'h06);
      pulse(3'b100, 8'h00);
      tick(2);
      chk("enables", 16'(en), 16'h000F);
      chk("pullups", 16'(pu), 16'h000F);
      drv(4'h1);
      wpf(1'b1);
      chk("irq wake", 16'({irq, wk}), 16'h0003);
      drv(4'h0);
      tick(8);
      pulse(3'b001, 8'h00);
      wpf(1'b0);
      pulse(3'b100, 8'h04);
      drv(4'h2);
      wpf(1'b1);
      drv(4'h3);
      pulse(3'b001, 8'h00);
      tick(10);
      chk("pending", 16'(pf), 16'h0000);
      drv(4'h0);
      tick(8);
      pulse(3'b100, 8'h02);
      drv(4'h1);
      wpf(1'b1);
      tick(2);
      chk("status", 16'(st), 16'h000A);
      chk("irq", 16'(irq), 16'h0000);
      @(posedge clk);
      bs <= 1'b1;
      pulse(3'b100, 8'h06);
      tick(3);
      chk("pending", 16'(pf), 16'h0001);
      @(posedge clk);
      bce <= 1'b1;
      pulse(3'b100, 8'h06);
      wpf(1'b0);
      @(posedge clk);
      {bs, bce} <= 2'b00;
      drv(4'h0);
      tick(8);
      chk("pending", 16'(pf), 16'h0000);
      pulse(3'b100, 8'h01);
      drv(4'h8);
      wpf(1'b1);
      pulse(3'b001, 8'h00);
      tick(10);
      chk("pending", 16'(pf), 16'h0001);
      drv(4'h0);
      wpf(1'b0);
      drv(4'h8);
      wpf(1'b1);
      drv(4'h0);
      tick(10);
      chk("pending", 16'(pf), 16'h0001);
      pulse(3'b100, 8'h05);
      wpf(1'b0);
      drv(4'h8);
      wpf(1'b1);
      @(posedge clk);
      rst <= 1'b1;
      tick(2);
      chk("status", 16'({st, 7'h00, pf}), 16'h0000);
      @(posedge clk);
      {rst, dir, dat} <= {1'b0, 4'hF, 4'hA};
      drv(4'h0);
      tick(3);
      chk("drive", 16'({oe, opin, rd}), 16'h0FAA);
      @(posedge clk);
      dat <= 4'hF;
      pulse(3'b010, 8'h0F);
      tick(2);
      chk("oe", 16'(oe), 16'h0000);
      @(posedge clk);
      dir <= 4'h0;
      drv(4'h1);
      tick(8);
      chk("read", 16'(rd), 16'h000E);
      give_verdict();
   end
endmodule
